// [rss_consts.svh]
// register map, command codes, field positions and timing counts of the step sequencer
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// ==================================================================
// register offsets (byte addresses)
`define RSS_A_CMD     8'h00
`define RSS_A_IDX     8'h04
`define RSS_A_FREQ    8'h08
`define RSS_A_AMPH    8'h0c
`define RSS_A_DURF    8'h10
`define RSS_A_RESULT  8'h14
`define RSS_A_CFG0    8'h20
`define RSS_A_LEN0    8'h30
`define RSS_A_STAT0   8'h40
`define RSS_A_CHMASK  8'hf3

// ==================================================================
// command codes
`define RSS_OP_WRITE  4'h1
`define RSS_OP_READ   4'h2
`define RSS_OP_WIPE   4'h3
`define RSS_OP_ADD    4'h4
`define RSS_OP_COPY   4'h5
`define RSS_OP_ARM    4'h6
`define RSS_OP_START  4'h7
`define RSS_OP_STOP   4'h8
`define RSS_OP_ALIGN  4'h9

// ==================================================================
// field positions
`define RSS_F_OP      3:0
`define RSS_F_MASK    7:4
`define RSS_F_CH      9:8
`define RSS_F_DCH     11:10
`define RSS_F_IDX     15:0
`define RSS_F_LEN     12:0
`define RSS_F_AMP     15:0
`define RSS_F_PHASE   31:16
`define RSS_F_DUR     23:0
`define RSS_F_FLAGS   26:24
`define RSS_B_RELOAD  0
`define RSS_B_REPEAT  1
`define RSS_B_FALL    2
`define RSS_B_SEQMODE 3
`define RSS_B_MUTE    0
`define RSS_B_PAOFF   1
`define RSS_B_WAIT    2
`define RSS_B_OK      0
`define RSS_B_ERR     1
`define RSS_B_BUSY    2

// ==================================================================
// sizes and reset values
`define RSS_FIRST_IDX 13'h0001
`define RSS_LAST_IDX  13'h1fff
`define RSS_LAST_IDXW 16'h1fff
`define RSS_LEN_RST   13'h0000
`define RSS_CFG_RST   4'h0
`define RSS_DUR_ZERO  24'h000000

// ==================================================================
// timebase
`define RSS_TICK_NS   5000
`define RSS_CLK_NS    8
`define RSS_TICK_CYC  ((`RSS_TICK_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)

`endif

// [rss_pkg.sv]
// types shared by the step sequencer
package rss_pkg;

    // ==================================================================
    // one table step
    typedef struct packed {
        logic [2:0]  flags;
        logic [23:0] dur;
        logic [15:0] phase;
        logic [15:0] amp;
        logic [31:0] freq;
    } rss_step_t;

    // ==================================================================
    // channel execution state
    typedef enum logic [4:0] {
        RSS_IDLE   = 5'h01,
        RSS_ARMED  = 5'h02,
        RSS_RUN    = 5'h04,
        RSS_ALIGN1 = 5'h08,
        RSS_ALIGN2 = 5'h10
    } rss_state_t;

    // ==================================================================
    // bulk table engine
    typedef enum logic [2:0] {
        RSS_ENG_IDLE = 3'h1,
        RSS_ENG_WIPE = 3'h2,
        RSS_ENG_COPY = 3'h4
    } rss_eng_t;

endpackage

// [rss_seq.sv]
// four channel step table sequencer with register port and trigger inputs
// Behaviour
// - step index 1..8191, others refused
// - duration counted in 5 us ticks
// - 24-bit duration reaches 83 seconds
// - zero duration holds until hardware trigger
// - mute flag disables signal this step only
// - amplifier-off flag acts this step only
// - wait flag behaves like zero duration
// - wipe halts channel and erases steps
// - length register holds final step index
// - add-last writes after end, bumps length
// - copy duplicates whole table between channels
// - arm readies; software or hardware starts
// - masked channels arm together
// - software start hits masked channels together
// - align: first trigger resets timebase, second starts
// - stop ends after current step, together
// - auto-reload re-arms after completion
// - auto-repeat restarts without a trigger
// - polarity picks rising or falling trigger
// - status shows channel execution state
// - read command returns stored step contents
// - every command reports ok or error
`timescale 1ns/1ps
`include "rss_consts.svh"

module rss_seq import rss_pkg::*; (
    input  wire logic            ref_clk,
    input  wire logic            rst_b,
    input  wire logic [7:0]      bus_addr,
    input  wire logic [31:0]     bus_wdata,
    input  wire logic            bus_wr,
    input  wire logic            bus_rd,
    output logic      [31:0]     bus_rdata,
    input  wire logic [3:0]      wait_external_flag_in,
    output rss_step_t [3:0]      dds_step,
    output logic      [3:0]      rf_on,
    output logic      [3:0]      pa_on
);

    // ==================================================================
    // helpers
    function automatic logic [14:0] tab_addr(input logic [1:0] ch, input logic [12:0] idx);
        tab_addr = {ch, idx};
    endfunction

    function automatic logic idx_ok(input logic [15:0] v);
        idx_ok = (v != 16'h0000) && (v <= `RSS_LAST_IDXW);
    endfunction

    function automatic logic hold_step(input rss_step_t s);
        hold_step = (s.dur == `RSS_DUR_ZERO) || s.flags[`RSS_B_WAIT];
    endfunction

    // ==================================================================
    // storage and registers
    rss_step_t       tbl_q [0:32767];
    rss_step_t       stage_q;
    rss_step_t       rb_q;
    logic [15:0]     idx_q;
    logic [12:0]     len_q [4];
    logic [3:0]      cfg_q [4];
    logic [2:0]      res_q;
    logic [31:0]     rdata_q;
    rss_eng_t        eng_q;
    logic [12:0]     eng_cnt_q;
    logic [1:0]      eng_src_q;
    logic [1:0]      eng_dst_q;
    rss_state_t      st_q [4];
    logic [12:0]     cur_q [4];
    logic [23:0]     dcnt_q [4];
    logic [9:0]      tick_q [4];
    logic [3:0]      stop_q;
    rss_step_t [3:0] out_q;
    logic [3:0]      rf_q;
    logic [3:0]      pa_q;
    logic [3:0]      s1_q;
    logic [3:0]      s2_q;
    logic [3:0]      s3_q;
    logic [3:0]      lvl_q;

    // ==================================================================
    // command decode
    logic            cmd_go;
    logic [3:0]      op;
    logic [3:0]      mask;
    logic [1:0]      cch;
    logic [1:0]      dch;
    logic            busy;
    logic            cmd_ok;
    logic            do_write;
    logic            do_read;
    logic            do_wipe;
    logic            do_add;
    logic            do_copy;
    logic [3:0]      arm_p;
    logic [3:0]      start_p;
    logic [3:0]      stop_p;
    logic [3:0]      align_p;
    logic [3:0]      seqm;

    assign cmd_go = bus_wr && (bus_addr == `RSS_A_CMD);
    assign op     = bus_wdata[`RSS_F_OP];
    assign mask   = bus_wdata[`RSS_F_MASK];
    assign cch    = bus_wdata[`RSS_F_CH];
    assign dch    = bus_wdata[`RSS_F_DCH];
    assign busy   = (eng_q != RSS_ENG_IDLE);

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            seqm[c] = cfg_q[c][`RSS_B_SEQMODE];
        end
    end

    always_comb begin
        cmd_ok   = 1'b0;
        do_write = 1'b0;
        do_read  = 1'b0;
        do_wipe  = 1'b0;
        do_add   = 1'b0;
        do_copy  = 1'b0;
        arm_p    = 4'h0;
        start_p  = 4'h0;
        stop_p   = 4'h0;
        align_p  = 4'h0;
        if (cmd_go && !busy) begin
            case (op)
                `RSS_OP_WRITE: begin
                    do_write = idx_ok(idx_q);
                    cmd_ok   = do_write;
                end
                `RSS_OP_READ: begin
                    do_read = idx_ok(idx_q);
                    cmd_ok  = do_read;
                end
                `RSS_OP_WIPE: begin
                    do_wipe = 1'b1;
                    cmd_ok  = 1'b1;
                end
                `RSS_OP_ADD: begin
                    do_add = (len_q[cch] != `RSS_LAST_IDX);
                    cmd_ok = do_add;
                end
                `RSS_OP_COPY: begin
                    do_copy = (cch != dch);
                    cmd_ok  = do_copy;
                end
                `RSS_OP_ARM: begin
                    cmd_ok = (mask != 4'h0) && ((mask & ~seqm) == 4'h0);
                    arm_p  = cmd_ok ? mask : 4'h0;
                end
                `RSS_OP_START: begin
                    cmd_ok  = (mask != 4'h0);
                    start_p = mask;
                end
                `RSS_OP_STOP: begin
                    cmd_ok = (mask != 4'h0);
                    stop_p = mask;
                end
                `RSS_OP_ALIGN: begin
                    cmd_ok  = (mask != 4'h0) && ((mask & ~seqm) == 4'h0);
                    align_p = cmd_ok ? mask : 4'h0;
                end
                default: begin
                    cmd_ok = 1'b0;
                end
            endcase
        end
    end

    // ==================================================================
    // command result
    // ok or error per command
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            res_q <= 3'h0;
        end else begin
            res_q[`RSS_B_BUSY] <= busy || do_wipe || do_copy;
            if (cmd_go) begin
                res_q[`RSS_B_OK]  <= cmd_ok;
                res_q[`RSS_B_ERR] <= !cmd_ok;
            end
        end
    end

    // ==================================================================
    // staging and readback registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            idx_q   <= 16'h0000;
            stage_q <= '0;
            rb_q    <= '0;
        end else begin
            if (bus_wr && bus_addr == `RSS_A_IDX) begin
                idx_q <= bus_wdata[`RSS_F_IDX];
            end
            if (bus_wr && bus_addr == `RSS_A_FREQ) begin
                stage_q.freq <= bus_wdata;
            end
            if (bus_wr && bus_addr == `RSS_A_AMPH) begin
                stage_q.amp   <= bus_wdata[`RSS_F_AMP];
                stage_q.phase <= bus_wdata[`RSS_F_PHASE];
            end
            if (bus_wr && bus_addr == `RSS_A_DURF) begin
                stage_q.dur   <= bus_wdata[`RSS_F_DUR];
                stage_q.flags <= bus_wdata[`RSS_F_FLAGS];
            end
            if (do_read) begin
                rb_q <= tbl_q[tab_addr(cch, idx_q[12:0])];
            end
        end
    end

    // ==================================================================
    // bulk engine for wipe and copy
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            eng_q     <= RSS_ENG_IDLE;
            eng_cnt_q <= `RSS_FIRST_IDX;
            eng_src_q <= 2'h0;
            eng_dst_q <= 2'h0;
        end else begin
            case (eng_q)
                RSS_ENG_IDLE: begin
                    eng_cnt_q <= `RSS_FIRST_IDX;
                    if (do_wipe) begin
                        eng_q     <= RSS_ENG_WIPE;
                        eng_dst_q <= cch;
                    end else if (do_copy) begin
                        eng_q     <= RSS_ENG_COPY;
                        eng_src_q <= cch;
                        eng_dst_q <= dch;
                    end
                end
                RSS_ENG_WIPE, RSS_ENG_COPY: begin
                    eng_cnt_q <= eng_cnt_q + 13'h0001;
                    if (eng_cnt_q == `RSS_LAST_IDX) begin
                        eng_q <= RSS_ENG_IDLE;
                    end
                end
                default: begin
                    eng_q <= RSS_ENG_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // table write port
    always_ff @(posedge ref_clk) begin
        if (eng_q == RSS_ENG_WIPE) begin
            tbl_q[tab_addr(eng_dst_q, eng_cnt_q)] <= '0;
        end else if (eng_q == RSS_ENG_COPY) begin
            tbl_q[tab_addr(eng_dst_q, eng_cnt_q)] <= tbl_q[tab_addr(eng_src_q, eng_cnt_q)];
        end else if (do_write) begin
            tbl_q[tab_addr(cch, idx_q[12:0])] <= stage_q;
        end else if (do_add) begin
            tbl_q[tab_addr(cch, len_q[cch] + 13'h0001)] <= stage_q;
        end
    end

    // ==================================================================
    // length and configuration registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            for (int c = 0; c < 4; c++) begin
                len_q[c] <= `RSS_LEN_RST;
                cfg_q[c] <= `RSS_CFG_RST;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (bus_wr && bus_addr == `RSS_A_LEN0 + 8'(4 * c)) begin
                    len_q[c] <= bus_wdata[`RSS_F_LEN];
                end
                if (bus_wr && bus_addr == `RSS_A_CFG0 + 8'(4 * c)) begin
                    cfg_q[c] <= bus_wdata[3:0];
                end
            end
            if (do_add) begin
                len_q[cch] <= len_q[cch] + 13'h0001;
            end
            if (do_wipe) begin
                len_q[cch] <= `RSS_LEN_RST;
            end
            if (do_copy) begin
                len_q[dch] <= len_q[cch];
            end
        end
    end

    // ==================================================================
    // trigger input synchroniser and edge pick
    logic [3:0] hw_edge;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s1_q  <= 4'h0;
            s2_q  <= 4'h0;
            s3_q  <= 4'h0;
            lvl_q <= 4'h0;
        end else begin
            s1_q <= wait_external_flag_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int c = 0; c < 4; c++) begin
                if (s2_q[c] == s3_q[c]) begin
                    lvl_q[c] <= s3_q[c];
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            hw_edge[c] = (s2_q[c] == s3_q[c]) && (s3_q[c] != lvl_q[c])
                         && (s3_q[c] == !cfg_q[c][`RSS_B_FALL]);
        end
    end

    // ==================================================================
    // per channel sequencer
    rss_step_t [3:0] cur_step;

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            cur_step[c] = tbl_q[tab_addr(2'(c), cur_q[c])];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            for (int c = 0; c < 4; c++) begin
                st_q[c]   <= RSS_IDLE;
                cur_q[c]  <= `RSS_FIRST_IDX;
                dcnt_q[c] <= `RSS_DUR_ZERO;
                tick_q[c] <= 10'h000;
            end
            stop_q <= 4'h0;
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (tick_q[c] == 10'(`RSS_TICK_CYC - 1)) begin
                    tick_q[c] <= 10'h000;
                end else begin
                    tick_q[c] <= tick_q[c] + 10'h001;
                end
                if (stop_p[c]) begin
                    stop_q[c] <= 1'b1;
                end
                case (st_q[c])
                    RSS_IDLE, RSS_ARMED: begin
                        stop_q[c] <= 1'b0;
                        if (arm_p[c]) begin
                            st_q[c]  <= RSS_ARMED;
                            cur_q[c] <= `RSS_FIRST_IDX;
                        end else if (align_p[c]) begin
                            st_q[c] <= RSS_ALIGN1;
                        end else if (st_q[c] == RSS_ARMED && stop_p[c]) begin
                            st_q[c] <= RSS_IDLE;
                        end else if (st_q[c] == RSS_ARMED && (start_p[c] || hw_edge[c])) begin
                            st_q[c]   <= RSS_RUN;
                            dcnt_q[c] <= `RSS_DUR_ZERO;
                            tick_q[c] <= 10'h000;
                        end
                    end
                    RSS_ALIGN1: begin
                        cur_q[c] <= `RSS_FIRST_IDX;
                        if (stop_p[c]) begin
                            st_q[c] <= RSS_IDLE;
                        end else if (hw_edge[c]) begin
                            tick_q[c] <= 10'h000;
                            st_q[c]   <= RSS_ALIGN2;
                        end
                    end
                    RSS_ALIGN2: begin
                        if (stop_p[c]) begin
                            st_q[c] <= RSS_IDLE;
                        end else if (hw_edge[c]) begin
                            st_q[c]   <= RSS_RUN;
                            dcnt_q[c] <= `RSS_DUR_ZERO;
                        end
                    end
                    RSS_RUN: begin
                        if (hold_step(cur_step[c]) ? hw_edge[c]
                            : (tick_q[c] == 10'(`RSS_TICK_CYC - 1)
                               && dcnt_q[c] + 24'h000001 >= cur_step[c].dur)) begin
                            dcnt_q[c] <= `RSS_DUR_ZERO;
                            if (stop_q[c] || stop_p[c]) begin
                                st_q[c]   <= RSS_IDLE;
                                stop_q[c] <= 1'b0;
                            end else if (cur_q[c] >= len_q[c]) begin
                                cur_q[c] <= `RSS_FIRST_IDX;
                                if (cfg_q[c][`RSS_B_REPEAT]) begin
                                    st_q[c] <= RSS_RUN;
                                end else if (cfg_q[c][`RSS_B_RELOAD]) begin
                                    st_q[c] <= RSS_ARMED;
                                end else begin
                                    st_q[c] <= RSS_IDLE;
                                end
                            end else begin
                                cur_q[c] <= cur_q[c] + 13'h0001;
                            end
                        end else if (tick_q[c] == 10'(`RSS_TICK_CYC - 1)) begin
                            dcnt_q[c] <= dcnt_q[c] + 24'h000001;
                        end
                    end
                    default: begin
                        st_q[c] <= RSS_IDLE;
                    end
                endcase
                if (do_wipe && cch == 2'(c)) begin
                    st_q[c]   <= RSS_IDLE;
                    stop_q[c] <= 1'b0;
                    cur_q[c]  <= `RSS_FIRST_IDX;
                end
            end
        end
    end

    // ==================================================================
    // rf outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            out_q <= '0;
            rf_q  <= 4'h0;
            pa_q  <= 4'h0;
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (st_q[c] == RSS_RUN || st_q[c] == RSS_ARMED) begin
                    out_q[c] <= cur_step[c];
                    rf_q[c] <= !cur_step[c].flags[`RSS_B_MUTE];
                    pa_q[c] <= !cur_step[c].flags[`RSS_B_PAOFF];
                end else begin
                    rf_q[c] <= 1'b0;
                    pa_q[c] <= 1'b0;
                end
            end
        end
    end

    assign dds_step = out_q;
    assign rf_on    = rf_q;
    assign pa_on    = pa_q;

    // ==================================================================
    // register read port
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_rd) begin
            rdata_q <= 32'h0000_0000;
            case (bus_addr)
                `RSS_A_IDX:    rdata_q <= {16'h0000, idx_q};
                `RSS_A_FREQ:   rdata_q <= rb_q.freq;
                `RSS_A_AMPH:   rdata_q <= {rb_q.phase, rb_q.amp};
                `RSS_A_DURF:   rdata_q <= {5'h00, rb_q.flags, rb_q.dur};
                `RSS_A_RESULT: rdata_q <= {29'h0000_0000, res_q};
                default: begin
                    for (int c = 0; c < 4; c++) begin
                        if (bus_addr == `RSS_A_CFG0 + 8'(4 * c)) begin
                            rdata_q <= {28'h000_0000, cfg_q[c]};
                        end
                        if (bus_addr == `RSS_A_LEN0 + 8'(4 * c)) begin
                            rdata_q <= {19'h0_0000, len_q[c]};
                        end
                        if (bus_addr == `RSS_A_STAT0 + 8'(4 * c)) begin
                            rdata_q <= {3'h0, cur_q[c], 9'h000, stop_q[c], 1'b0, st_q[c]};
                        end
                    end
                end
            endcase
        end
    end

    assign bus_rdata = rdata_q;

endmodule

// [rss_ttl_src.sv]
// external ttl trigger source model
`timescale 1ns/1ps
// ==========
module rss_ttl_src (
    input  wire logic       ref_clk,
    output logic      [3:0] wait_external_flag_in
);
    initial wait_external_flag_in = 4'h0;
    task automatic pulse(input int ch);
        wait_external_flag_in[ch] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wait_external_flag_in[ch] <= 1'b0;
    endtask
endmodule

// [rss_seq_chk.sv]
// port assertions for the step sequencer
`timescale 1ns/1ps
`include "rss_consts.svh"
// ==========
module rss_seq_chk import rss_pkg::*; (
    input wire logic            ref_clk,
    input wire logic            rst_b,
    input wire logic [7:0]      bus_addr,
    input wire logic [31:0]     bus_wdata,
    input wire logic            bus_wr,
    input wire logic            bus_rd,
    input wire logic [31:0]     bus_rdata,
    input wire rss_step_t [3:0] dds_step,
    input wire logic [3:0]      rf_on,
    input wire logic [3:0]      pa_on
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire rd_res = bus_rd && bus_addr == `RSS_A_RESULT;
    wire cmd_wr = bus_wr && bus_addr == `RSS_A_CMD;
    a_reset_quiet: assert property ($rose(rst_b) |-> rf_on == 4'h0 && pa_on == 4'h0)
        else $error("outputs live after reset");
    a_mute_off: assert property (rf_on[0] |-> !dds_step[0].flags[0]) else $error("rf on in muted step");
    a_amp_off: assert property (pa_on[0] |-> !dds_step[0].flags[1]) else $error("amp on in off step");
    a_cmd_reads: assert property (bus_rd && bus_addr == `RSS_A_CMD |=> bus_rdata == 32'h0)
        else $error("command reads nonzero");
    a_state_onehot: assert property (bus_rd && bus_addr == `RSS_A_STAT0 |=> $onehot(bus_rdata[4:0]))
        else $error("state not one-hot");
    a_wipe_busy: assert property (cmd_wr && bus_wdata[3:0] == `RSS_OP_WIPE ##1 rd_res |=> |bus_rdata[2:1])
        else $error("wipe not busy");
    a_stop_nomask: assert property (cmd_wr && bus_wdata == 32'h8 ##1 rd_res |=> bus_rdata[1:0] == 2'b10)
        else $error("stop without mask accepted");
    a_bad_op: assert property (cmd_wr && bus_wdata == 32'hf ##1 rd_res |=> bus_rdata[1:0] == 2'b10)
        else $error("unknown op accepted");
    cover property (rf_on[0] && pa_on[0]);
    cover property ($fell(rf_on[0]));
    cover property (cmd_wr && bus_wdata[3:0] == `RSS_OP_WIPE);
endmodule
bind rss_seq rss_seq_chk chk (.ref_clk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .dds_step, .rf_on, .pa_on);

// [rss_seq_bench.sv]
// self-checking bench for the step sequencer
`timescale 1ns/1ps
// ==========
module rss_seq_bench import rss_pkg::*;;
    logic            ref_clk = 1'b0;
    logic            rst_b = 1'b0;
    logic [7:0]      bus_addr = 8'h00;
    logic [31:0]     bus_wdata = 32'h0;
    logic            bus_wr = 1'b0;
    logic            bus_rd = 1'b0;
    logic [31:0]     bus_rdata;
    logic [3:0]      wait_external_flag_in;
    logic [3:0]      rf_on;
    logic [3:0]      pa_on;
    rss_step_t [3:0] dds_step;
    int              err_count = 0;
    int              samples_checked = 0;
    logic [31:0]     ix [3] = '{32'h0, 32'h1fff, 32'h2000};
    always #4 ref_clk = ~ref_clk;
    rss_seq uut (.ref_clk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .wait_external_flag_in, .dds_step, .rf_on, .pa_on);
    rss_ttl_src src (.ref_clk, .wait_external_flag_in);
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        bus_rd <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        bus_wr <= 1'b0;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        cmp(bus_rdata & m, e);
    endtask
    task automatic idle(input int n);
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        repeat (n - 1) @(posedge ref_clk);
    endtask
    task automatic stop_test;
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #400000 err_count++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        foreach (ix[i]) begin
            wr(8'h04, ix[i]);
            wr(8'h00, 32'h11);
            rd(8'h14, 32'h3, (ix[i] == 32'h1fff) ? 32'h1 : 32'h2);
        end
        wr(8'h20, 32'h8);
        wr(8'h24, 32'h8);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h12345678);
        wr(8'h0c, 32'h00030002);
        wr(8'h10, 32'h01000001);
        wr(8'h00, 32'h11);
        wr(8'h30, 32'h1);
        wr(8'h10, 32'h00000001);
        wr(8'h00, 32'h14);
        rd(8'h30, 32'h1fff, 32'h2);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h12);
        rd(8'h10, 32'h07ffffff, 32'h01000001);
        rd(8'h08, 32'hffffffff, 32'h12345678);
        wr(8'h00, 32'h36);
        idle(3);
        cmp({30'h0, pa_on[0], rf_on[0]}, 32'h2);
        rd(8'h40, 32'h1f, 32'h2);
        rd(8'h44, 32'h1f, 32'h2);
        wr(8'h00, 32'h17);
        idle(700);
        cmp({30'h0, pa_on[0], rf_on[0]}, 32'h3);
        idle(700);
        rd(8'h40, 32'h1f, 32'h1);
        wr(8'h00, 32'h16);
        idle(2);
        src.pulse(0);
        idle(300);
        cmp({30'h0, pa_on[0], rf_on[0]}, 32'h2);
        wr(8'h00, 32'h18);
        rd(8'h40, 32'h5f, 32'h44);
        idle(400);
        cmp({30'h0, pa_on[0], rf_on[0]}, 32'h0);
        rd(8'h40, 32'h5f, 32'h1);
        wr(8'h00, 32'h8);
        rd(8'h14, 32'h3, 32'h2);
        wr(8'h00, 32'hf);
        rd(8'h14, 32'h3, 32'h2);
        rd(8'h00, 32'hffffffff, 32'h0);
        wr(8'h00, 32'h13);
        rd(8'h14, 32'h4, 32'h4);
        idle(8200);
        rd(8'h14, 32'h4, 32'h0);
        rd(8'h30, 32'h1fff, 32'h0);
        wr(8'h00, 32'h12);
        rd(8'h10, 32'h07ffffff, 32'h0);
        stop_test;
    end
endmodule
